// [bench/wbch_nv_model.sv]
`timescale 1ns/1ps
`default_nettype none
// stand-in for the non-volatile image store beside the block
module wbch_nv_model (
    input wire logic clock,
    input wire logic nv_commit,
    output logic nv_image_valid,
    output logic [7:0] commit_cnt
);
    // the stored image outlives every reset, so the store has no reset
    logic saved_q = 1'b0;
    logic [7:0] cnt_q = 8'h00;
    // each commit pulse stores the image; a pulse held high counts once for every cycle it is high
    always @(posedge clock) begin
        if (nv_commit) begin
            saved_q <= 1'b1;
            cnt_q <= cnt_q + 8'h01;
        end
    end
    // a saved image is reported after every later reset
    assign nv_image_valid = saved_q;
    assign commit_cnt = cnt_q;
endmodule // wbch_nv_model
`default_nettype wire

// [bench/wbch_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module wbch_tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, nv_image_valid, nv_commit, cmd_busy;
    logic [1:0] ucode_sel;
    logic [7:0] commit_cnt;
    logic [31:0] rd;
    logic [2:0] resv [3] = '{3'h3, 3'h6, 3'h7};
    int err_total = 0;
    int total_checks = 0;
    //////////////////////////////////////////////////////////////////////////////////
    // block under test and the image store it commits to
    wbch_top #(.NB(2), .BUF_AW(8), .ALIGN_LOG2(0)) DUT (
        .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .nv_image_valid(nv_image_valid),
        .nv_commit(nv_commit), .ucode_sel(ucode_sel), .cmd_busy(cmd_busy));
    wbch_nv_model nv (.clock(clock), .nv_commit(nv_commit),
        .nv_image_valid(nv_image_valid), .commit_cnt(commit_cnt));
    // 50 MHz clock
    initial begin
        forever #10 clock = ~clock;
    end
    //////////////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // one bus access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge clock);
            n++;
        end
        if (n >= 50) begin
            err_total++;
            $display("BAD at %0t: no bus answer", $time);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask
    task automatic reg_is(input logic [5:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h00000000);
        chk(rd, exp, what);
    endtask
    // read one stored byte through the diagnostic port
    task automatic peek(input logic [1:0] rg, input logic [7:0] a, input logic [7:0] exp);
        bus(1'b1, wbch_pkg::REG_DADDR, {22'h000000, rg, a});
        bus(1'b0, wbch_pkg::REG_DDATA, 32'h00000000);
        chk(rd[7:0], exp, "buffer byte");
    endtask
    // full command: descriptor, start, data bytes, wait, answer and byte count
    task automatic cmd(input logic [7:0] op, input logic [2:0] mode, input logic [7:0] sel,
                       input logic [23:0] ofs, input logic [23:0] len, input logic [2:0] id,
                       input int nb, input logic [7:0] base, input logic ok,
                       input logic [23:0] xc);
        int n;
        bus(1'b1, wbch_pkg::REG_CDB0, {ofs[23:16], sel, 5'h00, mode, op});
        bus(1'b1, wbch_pkg::REG_CDB1, {len[15:8], len[23:16], ofs[7:0], ofs[15:8]});
        bus(1'b1, wbch_pkg::REG_CDB2, {24'h000000, len[7:0]});
        bus(1'b1, wbch_pkg::REG_CTRL, {25'h0000000, id, 4'h1});
        for (int i = 0; i < nb; i++) bus(1'b1, wbch_pkg::REG_DATA, {24'h000000, base + i[7:0]});
        n = 0;
        rd = 32'h00000000;
        while (rd[1:0] !== 2'b10 && n < 40) begin
            bus(1'b0, wbch_pkg::REG_STATUS, 32'h00000000);
            n++;
        end
        chk(rd[1:0], 2'b10, "command done");
        chk({rd[31:24], 4'h0, rd[19:16], rd[15:8]}, ok ?
            {wbch_pkg::ASC_NONE, 4'h0, wbch_pkg::SK_NONE, wbch_pkg::ST_GOOD} :
            {wbch_pkg::ASC_INV_CDB, 4'h0, wbch_pkg::SK_ILLEGAL, wbch_pkg::ST_CHECK}, "status");
        reg_is(wbch_pkg::REG_XCNT, {8'h00, xc}, "bytes taken");
    endtask
    task automatic do_reset(input int n);
        rst_n <= 1'b0;
        repeat (n) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
    endtask
    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        do_reset(8);
        chk(ucode_sel, wbch_pkg::UC_DEFAULT, "image at power up");
        chk(cmd_busy, 1'b0, "idle after reset");
        reg_is(wbch_pkg::REG_UA, {24'h000000, wbch_pkg::UA_RESET}, "attention at reset");
        bus(1'b1, 6'h30, 32'hFFFFFFFF);
        reg_is(6'h2C, 32'h00000000, "unmapped read");
        $display("test reset done");
        cmd(wbch_pkg::OPCODE, wbch_pkg::MODE_DATA, 8'h01, 24'h0A, 24'h03, 3'h0, 4, 8'hA0, 1, 3);
        peek(2'h1, 8'h0A, 8'hA0);
        peek(2'h1, 8'h0C, 8'hA2);
        cmd(wbch_pkg::OPCODE, wbch_pkg::MODE_DATA, 8'h02, 24'h0, 24'h1, 3'h0, 1, 8'h11, 0, 0);
        cmd(wbch_pkg::OPCODE, wbch_pkg::MODE_DATA, 8'h00, 24'h100, 24'h1, 3'h0, 1, 8'h22, 0, 0);
        cmd(wbch_pkg::OPCODE, wbch_pkg::MODE_DATA, 8'h00, 24'hFA, 24'h7, 3'h0, 7, 8'h33, 0, 0);
        cmd(wbch_pkg::OPCODE, wbch_pkg::MODE_DATA, 8'h00, 24'hFA, 24'h6, 3'h0, 7, 8'hB0, 1, 6);
        peek(2'h0, 8'hFF, 8'hB5);
        $display("test data mode done");
        cmd(wbch_pkg::OPCODE, wbch_pkg::MODE_COMB, 8'h00, 24'h0, 24'h6, 3'h0, 6, 8'hC0, 1, 6);
        peek(2'h0, 8'h00, 8'hC4);
        peek(2'h0, 8'h01, 8'hC5);
        cmd(wbch_pkg::OPCODE, wbch_pkg::MODE_COMB, 8'h00, 24'h0, 24'h101, 3'h0, 2, 8'hD0, 0, 0);
        cmd(wbch_pkg::OPCODE, wbch_pkg::MODE_VEND, 8'h01, 24'h14, 24'h1, 3'h0, 1, 8'h5A, 1, 1);
        peek(2'h1, 8'h14, 8'h5A);
        $display("test combined and vendor done");
        // reserved modes and a foreign opcode take no data
        for (int m = 0; m < 3; m++) cmd(wbch_pkg::OPCODE, resv[m], 8'h00, 24'h0, 24'h2, 3'h0, 2, 8'hE0, 0, 0);
        cmd(8'h3A, wbch_pkg::MODE_DATA, 8'h00, 24'h0, 24'h1, 3'h0, 1, 8'hE8, 0, 0);
        chk(commit_cnt, 8'h00, "store left alone");
        $display("test refusals done");
        cmd(wbch_pkg::OPCODE, wbch_pkg::MODE_DL, 8'h00, 24'h0, 24'h2, 3'h2, 2, 8'h70, 1, 2);
        peek(2'h2, 8'h01, 8'h71);
        reg_is(wbch_pkg::REG_UA, 32'h000000FB, "attention after load");
        chk(ucode_sel, wbch_pkg::UC_LIVE, "image after load");
        chk(commit_cnt, 8'h00, "no save on plain load");
        bus(1'b1, wbch_pkg::REG_UA, 32'h000000FF);
        reg_is(wbch_pkg::REG_UA, 32'h00000000, "attention cleared");
        cmd(wbch_pkg::OPCODE, wbch_pkg::MODE_DLSAVE, 8'h00, 24'h0, 24'h101, 3'h0, 2, 8'h80, 0, 0);
        chk(commit_cnt, 8'h00, "no save on failure");
        cmd(wbch_pkg::OPCODE, wbch_pkg::MODE_DLSAVE, 8'h00, 24'h0, 24'h2, 3'h0, 2, 8'h90, 1, 2);
        chk(commit_cnt, 8'h01, "one save pulse");
        reg_is(wbch_pkg::REG_UA, 32'h000000FE, "attention after save");
        $display("test download done");
        do_reset(3);
        chk(ucode_sel, wbch_pkg::UC_SAVED, "image after reset");
        reg_is(wbch_pkg::REG_UCODE, {28'h0000000, wbch_pkg::UC_SAVED, 2'b10}, "image register");
        reg_is(wbch_pkg::REG_UA, 32'h00000000, "attention after reset");
        $display("test second reset done");
        summarize();
    end
    // cut a hang short
    initial begin
        #400000;
        err_total++;
        $display("BAD at %0t: run did not finish", $time);
        summarize();
    end
endmodule // wbch_tb_top
`default_nettype wire

// [src/wbch_buf_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module wbch_buf_mem #(
    parameter int AW = 10
) (
    input wire logic clock,
    wbch_mem_if.mem mp
);
    logic [7:0] ram [0:(1<<AW)-1];
    logic [7:0] rdata_q;

    // byte write port
    always_ff @(posedge clock) begin
        if (mp.we) begin
            ram[mp.waddr] <= mp.wdata;
        end
    end

    // registered read port
    always_ff @(posedge clock) begin
        rdata_q <= ram[mp.raddr];
    end

    assign mp.rdata = rdata_q;
endmodule // wbch_buf_mem
`default_nettype wire

// [src/wbch_mem_if.sv]
`timescale 1ns/1ps
`default_nettype none
// one write port and one read port of the buffer memory
interface wbch_mem_if #(parameter int AW = 10) ();
    logic we;
    logic [AW-1:0] waddr;
    logic [7:0] wdata;
    logic [AW-1:0] raddr;
    logic [7:0] rdata;
    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface // wbch_mem_if
`default_nettype wire

// [src/wbch_pkg.sv]
package wbch_pkg;
    // command descriptor layout, byte indices
    localparam int CDB_OP = 0;
    localparam int CDB_MODE = 1;
    localparam int CDB_SEL = 2;
    localparam int CDB_OFS = 3;
    localparam int CDB_LEN = 6;
    localparam int MODE_LSB = 0;
    localparam logic [7:0] OPCODE = 8'h3B;
    // mode field codes and the combined-mode header length
    localparam logic [2:0] MODE_COMB = 3'h0;
    localparam logic [2:0] MODE_VEND = 3'h1;
    localparam logic [2:0] MODE_DATA = 3'h2;
    localparam logic [2:0] MODE_DL = 3'h4;
    localparam logic [2:0] MODE_DLSAVE = 3'h5;
    localparam logic [2:0] HDR_BYTES = 3'h4;
    // register byte offsets
    localparam logic [5:0] REG_CDB0 = 6'h00;
    localparam logic [5:0] REG_CDB1 = 6'h04;
    localparam logic [5:0] REG_CDB2 = 6'h08;
    localparam logic [5:0] REG_CTRL = 6'h0C;
    localparam logic [5:0] REG_DATA = 6'h10;
    localparam logic [5:0] REG_STATUS = 6'h14;
    localparam logic [5:0] REG_UA = 6'h18;
    localparam logic [5:0] REG_UCODE = 6'h1C;
    localparam logic [5:0] REG_XCNT = 6'h20;
    localparam logic [5:0] REG_DADDR = 6'h24;
    localparam logic [5:0] REG_DDATA = 6'h28;
    // control register fields
    localparam int CTRL_START = 0;
    localparam int CTRL_ID_LSB = 4;
    // answer codes
    localparam logic [7:0] ST_GOOD = 8'h00;
    localparam logic [7:0] ST_CHECK = 8'h02;
    localparam logic [3:0] SK_NONE = 4'h0;
    localparam logic [3:0] SK_ILLEGAL = 4'h5;
    localparam logic [7:0] ASC_NONE = 8'h00;
    localparam logic [7:0] ASC_INV_CDB = 8'h24;
    // microcode image in effect, buffer region select width, unit attention reset value
    localparam logic [1:0] UC_DEFAULT = 2'h0;
    localparam logic [1:0] UC_SAVED = 2'h1;
    localparam logic [1:0] UC_LIVE = 2'h2;
    localparam int REGION_W = 2;
    localparam logic [7:0] UA_RESET = 8'h00;
endpackage

// [src/wbch_top.sv]
`timescale 1ns/1ps
`default_nettype none
module wbch_top #(
    parameter int NB = 2,
    parameter int BUF_AW = 8,
    parameter int ALIGN_LOG2 = 0
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic nv_image_valid,
    output logic nv_commit,
    output logic [1:0] ucode_sel,
    output logic cmd_busy
);
    localparam int MAW = wbch_pkg::REGION_W + BUF_AW;
    localparam logic [24:0] DEPTH = 25'(1 << BUF_AW);

    typedef enum logic [3:0] {
        WBCH_IDLE = 4'b0001,
        WBCH_DECODE = 4'b0010,
        WBCH_XFER = 4'b0100,
        WBCH_FINISH = 4'b1000
    } wbch_state_e;

    wbch_state_e st_q, st_d;
    logic ack_q;
    logic [31:0] rdata_q, cdb0_q, cdb1_q, cdb2_q;
    logic [2:0] id_q, hdr_q;
    logic [23:0] rem_q, xcnt_q;
    logic [BUF_AW-1:0] woff_q;
    logic [1:0] reg_q;
    logic [7:0] status_q, asc_q, ua_q;
    logic [3:0] sk_q;
    logic done_q, live_q, boot_saved_q, boot_cap_q, nv_commit_q;
    logic [MAW-1:0] daddr_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    wbch_mem_if #(.AW(MAW)) mif ();
    wbch_buf_mem #(.AW(MAW)) u_mem (.clock(clock), .mp(mif));

    function automatic logic [7:0] cdb_byte(input logic [79:0] all, input int k);
        cdb_byte = all[8*k +: 8];
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            be_merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: every access waits one cycle, then completes
    wire acc = avs_read | avs_write;
    wire wr_fire = avs_write & ack_q;
    wire wr_cdb0 = wr_fire & (avs_address == wbch_pkg::REG_CDB0);
    wire wr_cdb1 = wr_fire & (avs_address == wbch_pkg::REG_CDB1);
    wire wr_cdb2 = wr_fire & (avs_address == wbch_pkg::REG_CDB2);
    wire wr_ctrl = wr_fire & (avs_address == wbch_pkg::REG_CTRL);
    wire wr_data = wr_fire & (avs_address == wbch_pkg::REG_DATA) & avs_byteenable[0];
    wire wr_ua = wr_fire & (avs_address == wbch_pkg::REG_UA);
    wire wr_daddr = wr_fire & (avs_address == wbch_pkg::REG_DADDR);
    wire cdb_open = (st_q == WBCH_IDLE);
    wire start = wr_ctrl & avs_writedata[wbch_pkg::CTRL_START] & (st_q == WBCH_IDLE);
    assign avs_waitrequest = acc & ~ack_q;
    assign avs_readdata = rdata_q;

    // read mux, sampled in the waiting cycle
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        unique case (avs_address)
            wbch_pkg::REG_CDB0: rd_mux = cdb0_q;
            wbch_pkg::REG_CDB1: rd_mux = cdb1_q;
            wbch_pkg::REG_CDB2: rd_mux = {16'h0000, cdb2_q[15:0]};
            wbch_pkg::REG_CTRL: rd_mux = {25'h0000000, id_q, 4'h0};
            wbch_pkg::REG_STATUS: rd_mux = {asc_q, 4'h0, sk_q, status_q, 6'h00, done_q, cmd_busy};
            wbch_pkg::REG_UA: rd_mux = {24'h000000, ua_q};
            wbch_pkg::REG_UCODE: rd_mux = {28'h0000000, ucode_sel, boot_saved_q, live_q};
            wbch_pkg::REG_XCNT: rd_mux = {8'h00, xcnt_q};
            wbch_pkg::REG_DADDR: rd_mux = 32'(daddr_q);
            wbch_pkg::REG_DDATA: rd_mux = {24'h000000, mif.rdata};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= acc & ~ack_q;
            rdata_q <= rd_mux;
        end
    end

    // descriptor and diagnostic address registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cdb0_q <= 32'h00000000;
            cdb1_q <= 32'h00000000;
            cdb2_q <= 32'h00000000;
            id_q <= 3'h0;
            daddr_q <= '0;
        end else begin
            if (wr_cdb0 && cdb_open) cdb0_q <= be_merge(cdb0_q, avs_writedata, avs_byteenable);
            if (wr_cdb1 && cdb_open) cdb1_q <= be_merge(cdb1_q, avs_writedata, avs_byteenable);
            if (wr_cdb2 && cdb_open) cdb2_q <= be_merge(cdb2_q, avs_writedata, avs_byteenable);
            if (start) id_q <= avs_writedata[wbch_pkg::CTRL_ID_LSB +: 3];
            if (wr_daddr) daddr_q <= avs_writedata[MAW-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // descriptor decode
    wire [79:0] cdb_all = {cdb2_q[15:0], cdb1_q, cdb0_q};
    wire [7:0] op = cdb_byte(cdb_all, wbch_pkg::CDB_OP);
    wire [7:0] mode_byte = cdb_byte(cdb_all, wbch_pkg::CDB_MODE);
    wire [2:0] mode = mode_byte[wbch_pkg::MODE_LSB +: 3];
    wire [7:0] sel = cdb_byte(cdb_all, wbch_pkg::CDB_SEL);
    wire [23:0] ofs = {cdb_byte(cdb_all, wbch_pkg::CDB_OFS),
                       cdb_byte(cdb_all, wbch_pkg::CDB_OFS + 1),
                       cdb_byte(cdb_all, wbch_pkg::CDB_OFS + 2)};
    wire [23:0] len = {cdb_byte(cdb_all, wbch_pkg::CDB_LEN),
                       cdb_byte(cdb_all, wbch_pkg::CDB_LEN + 1),
                       cdb_byte(cdb_all, wbch_pkg::CDB_LEN + 2)};
    wire m_comb = (mode == wbch_pkg::MODE_COMB);
    wire m_buf = (mode == wbch_pkg::MODE_DATA) | (mode == wbch_pkg::MODE_VEND);
    wire m_dl = (mode == wbch_pkg::MODE_DL) | (mode == wbch_pkg::MODE_DLSAVE);
    wire m_rsv = ~(m_comb | m_buf | m_dl);
    wire bad_op = (op != wbch_pkg::OPCODE);
    wire bad_sel = m_buf & (32'(sel) >= 32'(NB));
    wire ofs_misal = (ALIGN_LOG2 > 0) && ((ofs & 24'((1 << ALIGN_LOG2) - 1)) != 24'h000000);
    wire bad_ofs = m_buf & ((25'(ofs) >= DEPTH) | ofs_misal);
    wire overrun = m_buf & ((25'(ofs) + 25'(len)) > DEPTH);
    wire comb_big = (m_comb | m_dl) & (25'(len) > DEPTH);
    wire dec_err = bad_op | m_rsv | bad_sel | bad_ofs | overrun | comb_big;
    wire [1:0] region = m_dl ? 2'(NB) : (m_buf ? sel[1:0] : 2'h0);

    ////////////////////////////////////////////////////////////////////////////
    // command sequencer
    wire take = (st_q == WBCH_XFER) & wr_data;
    wire skip_hdr = (hdr_q != 3'h0);
    wire fin_ok = (st_q == WBCH_FINISH) & (status_q == wbch_pkg::ST_GOOD);
    wire dl_ok = fin_ok & (mode == wbch_pkg::MODE_DL | mode == wbch_pkg::MODE_DLSAVE);

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            WBCH_IDLE: if (start) st_d = WBCH_DECODE;
            WBCH_DECODE: st_d = (dec_err || len == 24'h000000) ? WBCH_FINISH : WBCH_XFER;
            WBCH_XFER: if (take && rem_q == 24'h000001) st_d = WBCH_FINISH;
            WBCH_FINISH: st_d = WBCH_IDLE;
            default: st_d = WBCH_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) st_q <= WBCH_IDLE;
        else st_q <= st_d;
    end

    // transfer counters: header skip, remaining bytes, write address
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rem_q <= 24'h000000;
            hdr_q <= 3'h0;
            woff_q <= '0;
            reg_q <= 2'h0;
            xcnt_q <= 24'h000000;
        end else if (st_q == WBCH_DECODE) begin
            rem_q <= len;
            hdr_q <= m_comb ? wbch_pkg::HDR_BYTES : 3'h0;
            woff_q <= m_buf ? ofs[BUF_AW-1:0] : '0;
            reg_q <= region;
            xcnt_q <= 24'h000000;
        end else if (take) begin
            rem_q <= rem_q - 24'h000001;
            xcnt_q <= xcnt_q + 24'h000001;
            if (skip_hdr) hdr_q <= hdr_q - 3'h1;
            else woff_q <= woff_q + BUF_AW'(1);
        end
    end

    // completion status and sense
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= wbch_pkg::ST_GOOD;
            sk_q <= wbch_pkg::SK_NONE;
            asc_q <= wbch_pkg::ASC_NONE;
            done_q <= 1'b0;
        end else if (start) begin
            status_q <= wbch_pkg::ST_GOOD;
            sk_q <= wbch_pkg::SK_NONE;
            asc_q <= wbch_pkg::ASC_NONE;
            done_q <= 1'b0;
        end else if (st_q == WBCH_DECODE && dec_err) begin
            status_q <= wbch_pkg::ST_CHECK;
            sk_q <= wbch_pkg::SK_ILLEGAL;
            asc_q <= wbch_pkg::ASC_INV_CDB;
        end else if (st_q == WBCH_FINISH) begin
            done_q <= 1'b1;
        end
    end

    // buffer writes; header bytes are dropped, media are never touched here
    assign mif.we = take & ~skip_hdr;
    assign mif.waddr = {reg_q, woff_q};
    assign mif.wdata = avs_writedata[7:0];
    assign mif.raddr = daddr_q;
    assign cmd_busy = (st_q != WBCH_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // microcode image state and unit attention
    wire [7:0] ua_set = dl_ok ? ~(8'h01 << id_q) : 8'h00;
    wire [7:0] ua_clr = wr_ua ? avs_writedata[7:0] : 8'h00;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ua_q <= wbch_pkg::UA_RESET;
            live_q <= 1'b0;
            nv_commit_q <= 1'b0;
        end else begin
            ua_q <= (ua_q & ~ua_clr) | ua_set;
            if (dl_ok) live_q <= 1'b1;
            nv_commit_q <= fin_ok & (mode == wbch_pkg::MODE_DLSAVE);
        end
    end

    // saved-image flag caught from the store once after reset release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            boot_cap_q <= 1'b0;
            boot_saved_q <= 1'b0;
        end else if (!boot_cap_q) begin
            boot_cap_q <= 1'b1;
            boot_saved_q <= nv_image_valid;
        end else if (nv_commit_q) begin
            boot_saved_q <= 1'b1;
        end
    end

    assign nv_commit = nv_commit_q;
    assign ucode_sel = live_q ? wbch_pkg::UC_LIVE :
                       (boot_saved_q ? wbch_pkg::UC_SAVED : wbch_pkg::UC_DEFAULT);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_reserved_mode_rej: assert property ((st_q == WBCH_DECODE && m_rsv) |=>
        (st_q == WBCH_FINISH && status_q == wbch_pkg::ST_CHECK && !mif.we))
        else $error("reserved mode not rejected");
    a_bad_sel_rej: assert property ((st_q == WBCH_DECODE && bad_sel) |=>
        (asc_q == wbch_pkg::ASC_INV_CDB && sk_q == wbch_pkg::SK_ILLEGAL))
        else $error("bad selector not rejected");
    a_bad_offset_rej: assert property ((st_q == WBCH_DECODE && bad_ofs) |=>
        (status_q == wbch_pkg::ST_CHECK) ##1 (st_q == WBCH_IDLE && done_q))
        else $error("bad offset not rejected");
    a_overrun_rej: assert property ((st_q == WBCH_DECODE && overrun) |=>
        !mif.we [*2])
        else $error("overrun transfer took data");
    a_comb_cap_rej: assert property ((st_q == WBCH_DECODE && m_comb && comb_big) |=>
        (status_q == wbch_pkg::ST_CHECK && st_q == WBCH_FINISH))
        else $error("combined capacity not enforced");
    // the first header-sized run of bytes taken in combined mode must never reach the buffer
    a_header_dropped: assert property ((take && m_comb && xcnt_q < 24'(wbch_pkg::HDR_BYTES)) |->
        !mif.we)
        else $error("header byte stored");
    a_length_bound: assert property ((take && rem_q == 24'h000001) |=>
        (st_q == WBCH_FINISH) ##1 (st_q == WBCH_IDLE))
        else $error("took more than the length");
    a_seq_address: assert property ((mif.we && st_q == WBCH_XFER) |=>
        (mif.waddr[BUF_AW-1:0] == $past(mif.waddr[BUF_AW-1:0]) + BUF_AW'(1)))
        else $error("buffer address not sequential");
    a_ua_others: assert property (dl_ok |=>
        ((ua_q | (8'h01 << id_q)) == 8'hFF))
        else $error("unit attention not raised for others");
    a_nv_only_save: assert property (nv_commit |->
        ($past(fin_ok) && mode == wbch_pkg::MODE_DLSAVE))
        else $error("commit without successful save");
    c_comb_ok: cover property ((st_q == WBCH_FINISH) && m_comb && status_q == wbch_pkg::ST_GOOD);
    c_data_err: cover property ((st_q == WBCH_FINISH) && m_buf && status_q == wbch_pkg::ST_CHECK);
    c_save_done: cover property (nv_commit);
endmodule // wbch_top
`default_nettype wire
